// ===== rtl/nctrr_pkg.sv
// Purpose: shared constants for the table-read, return and rotate executor
// Assumes: 8-bit opcodes, 4-bit data path, 13-bit rom address, 12-bit pc
// Notes: opcodes and field positions for the rtl live here; the bench spells opcodes as literals
`default_nettype none
package nctrr_pkg;
  localparam int DATA_W = 4;
  localparam int PC_W = 12;
  localparam int ROM_AW = 13;
  localparam int MEM_AW = 8;
  localparam logic [7:0] OP_HIGH_PAGE_TABLE_READ_TO_WORK_REG = 8'h4e;
  localparam logic [7:0] OP_SUBROUTINE_RETURN = 8'h2e;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h2f;
  localparam logic [7:0] OP_ROTATE_LEFT_PLAIN = 8'h01;
  localparam logic [7:0] OP_ROTATE_LEFT_THROUGH_CARRY = 8'h03;
  // fixed high page: address bits 11~8 are all ones, bit 12 is port a bit three
  localparam logic [3:0] HIGH_PAGE_ONES = 4'hf;
  localparam int ROM_PORT_BIT_POS = 12;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RST = 4'h0;
  localparam logic [DATA_W-1:0] FWR_RST = 4'h0;
  localparam logic [MEM_AW-1:0] MEM_ADDR_RST = 8'h00;
  localparam logic [ROM_AW-1:0] ROM_ADDR_RST = 13'h0000;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM_RD = 2'b01,
    ST_ROM_RD = 2'b10
  } nctrr_state_t;
endpackage
`default_nettype wire

// ===== rtl/nctrr_rotate.sv
// Purpose: left rotate of the accumulator, plain or through carry
// Assumes: purely combinational, used by the executor
// Notes: none
`timescale 1ns/1ns
`default_nettype none
module nctrr_rotate (
  input wire logic [3:0] acc_i,
  input wire logic carry_i,
  input wire logic through_carry_i,
  output logic [3:0] acc_o,
  output logic carry_o
);
  always_comb begin
    // bit 3 always lands in carry; bit 0 takes bit 3 or the old carry
    acc_o = {acc_i[2:0], through_carry_i ? carry_i : acc_i[3]}; // see RULE6 see RULE7
    carry_o = acc_i[3]; // see RULE6 see RULE7
  end
endmodule
`default_nettype wire

// ===== rtl/nctrr_core.sv
// Purpose: executes table read from the high page, returns and left rotates
// Assumes: rom and data memory answer in the same cycle as their read strobes
// Notes: one-level return stack; carry saved beside it on interrupt entry
//
// Operation
// RULE1 - opcode 4e fetches one 8-bit rom word from the fixed high page
// RULE2 - rom address is port a bit three, ones, accumulator, pointed memory nibble
// RULE3 - high nibble goes to fourth working register, low nibble to accumulator
// RULE4 - subroutine return reloads pc bits 0~11 from the return stack
// RULE5 - interrupt return reloads pc and restores carry saved at interrupt entry
// RULE6 - plain left rotate moves bit 3 to bit 0 and carry
// RULE7 - rotate through carry puts old carry in bit 0, bit 3 in carry
// RULE8 - interrupt entry saves carry alongside the return address
`timescale 1ns/1ns
`default_nettype none
module nctrr_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire logic [7:0] op_i,
  input wire logic call_i,
  input wire logic [11:0] call_target_i,
  input wire logic int_entry_i,
  input wire logic [11:0] int_vector_i,
  input wire logic acc_load_i,
  input wire logic [3:0] acc_data_i,
  input wire logic [7:0] memory_pointer_pair_i,
  input wire logic [3:0] mem_rdata_i,
  input wire logic [7:0] rom_data_i,
  input wire logic port_a_bit_three_i,
  output logic busy_o,
  output logic mem_rd_o,
  output logic [7:0] mem_addr_o,
  output logic rom_rd_o,
  output logic [12:0] rom_addr_o,
  output logic [3:0] acc_o,
  output logic [3:0] fourth_working_register_o,
  output logic carry_o,
  output logic [11:0] pc_o
);
  nctrr_pkg::nctrr_state_t state_r, state_nxt;
  logic [nctrr_pkg::DATA_W-1:0] acc_r, acc_nxt, fwr_r, fwr_nxt;
  logic carry_r, carry_nxt, saved_carry_r, saved_carry_nxt;
  logic [nctrr_pkg::PC_W-1:0] pc_r, pc_nxt, stack_r, stack_nxt;
  logic mem_rd_r, mem_rd_nxt, rom_rd_r, rom_rd_nxt, busy_r, busy_nxt;
  logic [nctrr_pkg::MEM_AW-1:0] mem_addr_r, mem_addr_nxt;
  logic [nctrr_pkg::ROM_AW-1:0] rom_addr_r, rom_addr_nxt;
  logic idle, int_take, call_take, op_take;
  logic [3:0] rot_acc;
  logic rot_carry;

  nctrr_rotate u_rotate (
    .acc_i(acc_r),
    .carry_i(carry_r),
    .through_carry_i(op_i == nctrr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY),
    .acc_o(rot_acc),
    .carry_o(rot_carry)
  );

  // interrupt entry beats a call, a call beats an opcode; the loser is dropped
  assign idle = (state_r == nctrr_pkg::ST_IDLE);
  assign int_take = idle && int_entry_i;
  assign call_take = idle && !int_entry_i && call_i;
  assign op_take = idle && !int_entry_i && !call_i && op_valid_i;

  always_comb begin
    state_nxt = state_r;
    acc_nxt = acc_r;
    fwr_nxt = fwr_r;
    carry_nxt = carry_r;
    saved_carry_nxt = saved_carry_r;
    pc_nxt = pc_r;
    stack_nxt = stack_r;
    mem_rd_nxt = 1'b0;
    rom_rd_nxt = 1'b0;
    busy_nxt = busy_r;
    mem_addr_nxt = mem_addr_r;
    rom_addr_nxt = rom_addr_r;
    case (state_r)
      nctrr_pkg::ST_IDLE: begin
        if (int_take) begin
          stack_nxt = pc_r;
          saved_carry_nxt = carry_r; // see RULE8
          pc_nxt = int_vector_i;
        end else if (call_take) begin
          // one-level stack: a nested call overwrites the saved address
          stack_nxt = pc_r + nctrr_pkg::PC_STEP;
          pc_nxt = call_target_i;
        end else if (op_take) begin
          pc_nxt = pc_r + nctrr_pkg::PC_STEP;
          if (op_i == nctrr_pkg::OP_HIGH_PAGE_TABLE_READ_TO_WORK_REG) begin
            mem_rd_nxt = 1'b1; // see RULE1
            mem_addr_nxt = memory_pointer_pair_i;
            busy_nxt = 1'b1;
            state_nxt = nctrr_pkg::ST_MEM_RD;
          end else if (op_i == nctrr_pkg::OP_SUBROUTINE_RETURN) begin
            pc_nxt = stack_r; // see RULE4
          end else if (op_i == nctrr_pkg::OP_INTERRUPT_RETURN) begin
            pc_nxt = stack_r; // see RULE5
            carry_nxt = saved_carry_r; // see RULE5
          end else if (op_i == nctrr_pkg::OP_ROTATE_LEFT_PLAIN ||
                       op_i == nctrr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) begin
            acc_nxt = rot_acc; // see RULE6 see RULE7
            carry_nxt = rot_carry;
          end
        end else if (acc_load_i) begin
          acc_nxt = acc_data_i;
        end
      end
      nctrr_pkg::ST_MEM_RD: begin
        // port a bit three is sampled now, not at opcode time
        rom_addr_nxt = {port_a_bit_three_i, nctrr_pkg::HIGH_PAGE_ONES, acc_r, mem_rdata_i}; // see RULE2
        rom_rd_nxt = 1'b1; // see RULE1
        state_nxt = nctrr_pkg::ST_ROM_RD;
      end
      nctrr_pkg::ST_ROM_RD: begin
        fwr_nxt = rom_data_i[7:4]; // see RULE3
        acc_nxt = rom_data_i[3:0]; // see RULE3
        busy_nxt = 1'b0;
        state_nxt = nctrr_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = nctrr_pkg::ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= nctrr_pkg::ST_IDLE;
      acc_r <= nctrr_pkg::ACC_RST;
      fwr_r <= nctrr_pkg::FWR_RST;
      carry_r <= nctrr_pkg::CARRY_RST;
      saved_carry_r <= nctrr_pkg::CARRY_RST;
      pc_r <= nctrr_pkg::PC_RST;
      stack_r <= nctrr_pkg::PC_RST;
      mem_rd_r <= 1'b0;
      rom_rd_r <= 1'b0;
      busy_r <= 1'b0;
      mem_addr_r <= nctrr_pkg::MEM_ADDR_RST;
      rom_addr_r <= nctrr_pkg::ROM_ADDR_RST;
    end else begin
      state_r <= state_nxt;
      acc_r <= acc_nxt;
      fwr_r <= fwr_nxt;
      carry_r <= carry_nxt;
      saved_carry_r <= saved_carry_nxt;
      pc_r <= pc_nxt;
      stack_r <= stack_nxt;
      mem_rd_r <= mem_rd_nxt;
      rom_rd_r <= rom_rd_nxt;
      busy_r <= busy_nxt;
      mem_addr_r <= mem_addr_nxt;
      rom_addr_r <= rom_addr_nxt;
    end
  end

  assign busy_o = busy_r;
  assign mem_rd_o = mem_rd_r;
  assign mem_addr_o = mem_addr_r;
  assign rom_rd_o = rom_rd_r;
  assign rom_addr_o = rom_addr_r;
  assign acc_o = acc_r;
  assign fourth_working_register_o = fwr_r;
  assign carry_o = carry_r;
  assign pc_o = pc_r;

  AST_TABLE_READ_SEQ: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    op_take && op_i == nctrr_pkg::OP_HIGH_PAGE_TABLE_READ_TO_WORK_REG |=> mem_rd_o && busy_o ##1 rom_rd_o ##1 !busy_o)
    else $error("table read did not sequence memory then rom");
  AST_TABLE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    $rose(rom_rd_o) |->
    rom_addr_o == {$past(port_a_bit_three_i), nctrr_pkg::HIGH_PAGE_ONES, acc_o, $past(mem_rdata_i)})
    else $error("high page rom address wrong");
  AST_TABLE_WB: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE3
    rom_rd_o |=> fourth_working_register_o == $past(rom_data_i[7:4]) && acc_o == $past(rom_data_i[3:0]))
    else $error("rom word not split into fourth working register and acc");
  AST_RET_PC: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE4
    op_take && op_i == nctrr_pkg::OP_SUBROUTINE_RETURN |=> pc_o == $past(stack_r) && carry_o == $past(carry_o))
    else $error("return did not reload pc");
  AST_INTERRUPT_RETURN_CARRY: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE5
    op_take && op_i == nctrr_pkg::OP_INTERRUPT_RETURN |=> pc_o == $past(stack_r) && carry_o == $past(saved_carry_r))
    else $error("interrupt return did not restore pc and carry");
  AST_RL_PLAIN: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE6
    op_take && op_i == nctrr_pkg::OP_ROTATE_LEFT_PLAIN |=> acc_o == {$past(acc_o[2:0]), $past(acc_o[3])} &&
    carry_o == $past(acc_o[3]))
    else $error("plain left rotate wrong");
  AST_RL_CARRY: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
    op_take && op_i == nctrr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY |=> acc_o == {$past(acc_o[2:0]), $past(carry_o)} &&
    carry_o == $past(acc_o[3]))
    else $error("left rotate through carry wrong");
  AST_INT_SAVE: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE8
    int_take |=> saved_carry_r == $past(carry_o) && stack_r == $past(pc_o) && pc_o == $past(int_vector_i))
    else $error("interrupt entry did not save carry and pc");

  // strobes are single-cycle so a slow memory cannot see a stale second request
  AST_MEM_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    mem_rd_o |=> !mem_rd_o)
    else $error("memory read strobe longer than one cycle");
  AST_ROM_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    rom_rd_o |=> !rom_rd_o)
    else $error("rom read strobe longer than one cycle");
  AST_MEM_ADDR: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    op_take && op_i == nctrr_pkg::OP_HIGH_PAGE_TABLE_READ_TO_WORK_REG |=> mem_addr_o == $past(memory_pointer_pair_i))
    else $error("table read used wrong memory pointer");
  AST_ROM_PORT_BIT: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    $rose(rom_rd_o) |-> rom_addr_o[nctrr_pkg::ROM_PORT_BIT_POS] == $past(port_a_bit_three_i))
    else $error("rom address top bit not from port a bit three");
  // the accumulator forms address bits 7~4, so it must not move before the rom answers
  AST_TABLE_ACC_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    busy_o && !rom_rd_o |=> acc_o == $past(acc_o))
    else $error("accumulator changed during table read");
  AST_BUSY_REFUSE: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    busy_o |=> pc_o == $past(pc_o))
    else $error("request taken while table read busy");
  AST_TABLE_PC: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    op_take && op_i == nctrr_pkg::OP_HIGH_PAGE_TABLE_READ_TO_WORK_REG |=> pc_o == $past(pc_o) + nctrr_pkg::PC_STEP)
    else $error("table read did not advance pc by one");
  AST_RL_SCOPE: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE6
    op_take && (op_i == nctrr_pkg::OP_ROTATE_LEFT_PLAIN || op_i == nctrr_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) |=>
    pc_o == $past(pc_o) + nctrr_pkg::PC_STEP &&
    fourth_working_register_o == $past(fourth_working_register_o))
    else $error("rotate touched more than accumulator and carry");
endmodule
`default_nettype wire

// ===== bench/nctrr_mem_model.sv
// Purpose: rom and data memory partner of the executor
// Assumes: data answers while the read strobe is high
// Notes: idle buses show the inverse so stale data never matches
`timescale 1ns/1ns
`default_nettype none
module nctrr_mem_model (
  input wire logic mem_rd_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic rom_rd_i,
  input wire logic [12:0] rom_addr_i,
  output logic [3:0] mem_rdata_o,
  output logic [7:0] rom_data_o
);
  logic [3:0] m;
  logic [7:0] r;
  assign m = mem_addr_i[3:0] ^ 4'h9;
  assign r = {rom_addr_i[3:0], rom_addr_i[7:4]} ^ {7'h00, rom_addr_i[12]};
  assign mem_rdata_o = mem_rd_i ? m : ~m;
  assign rom_data_o = rom_rd_i ? r : ~r;
endmodule
`default_nettype wire

// ===== bench/test_nctrr_core.sv
// Purpose: self-checking bench for the executor
// Assumes: inputs change on the falling edge
// Notes: pc expectations come from call targets, not from reset history
`timescale 1ns/1ns
`default_nettype none
module test_nctrr_core;
  logic clk_i = 0, rst_i = 1, op_valid_i = 0, call_i = 0, int_entry_i = 0, acc_load_i = 0, pab3 = 0;
  logic [7:0] op_i = 8'h00, ptr = 8'h00, rd, mb;
  logic [11:0] tgt = 12'h000, vec = 12'h000;
  logic [3:0] acc_data_i = 4'h0, mrd, acc, fwr, a;
  logic [12:0] raddr, ea;
  logic busy, mrdo, rrdo, carry;
  logic [11:0] pc;
  int miscompares = 0, checked = 0;
  nctrr_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i), .call_i(call_i),
    .call_target_i(tgt), .int_entry_i(int_entry_i), .int_vector_i(vec), .acc_load_i(acc_load_i),
    .acc_data_i(acc_data_i), .memory_pointer_pair_i(ptr), .mem_rdata_i(mrd), .rom_data_i(rd),
    .port_a_bit_three_i(pab3), .busy_o(busy), .mem_rd_o(mrdo), .mem_addr_o(mb), .rom_rd_o(rrdo),
    .rom_addr_o(raddr), .acc_o(acc), .fourth_working_register_o(fwr), .carry_o(carry), .pc_o(pc));
  nctrr_mem_model mem_u (.mem_rd_i(mrdo), .mem_addr_i(mb), .rom_rd_i(rrdo), .rom_addr_i(raddr),
    .mem_rdata_o(mrd), .rom_data_o(rd));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [7:0] code);
    op_i = code;
    op_valid_i = 1'b1;
    @(negedge clk_i);
    op_valid_i = 1'b0;
    // idle cycle so a following request never re-raises valid in the same step
    @(negedge clk_i);
  endtask
  task automatic load(input logic [3:0] v);
    acc_data_i = v;
    acc_load_i = 1'b1;
    @(negedge clk_i);
    acc_load_i = 1'b0;
  endtask
  task automatic call(input logic [11:0] t, input logic irq);
    tgt = t;
    vec = t;
    call_i = !irq;
    int_entry_i = irq;
    @(negedge clk_i);
    call_i = 1'b0;
    int_entry_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic t_rotate();
    for (int v = 0; v < 16; v++) begin
      a = v[3:0];
      load(a);
      go(8'h01);
      chk({carry, acc}, {a[3], a[2:0], a[3]});
      go(8'h03);
      chk({carry, acc}, {a[2], a[1:0], a[3], a[3]});
    end
  endtask
  task automatic t_table();
    for (int k = 0; k < 4; k++) begin
      a = 4'(k * 5);
      ptr = 8'(8'h30 + k * 7);
      pab3 = k[0];
      load(a);
      op_i = 8'h4e;
      op_valid_i = 1'b1;
      @(negedge clk_i);
      op_valid_i = 1'b0;
      chk({mrdo, busy, mb}, {2'b11, ptr});
      ea = {pab3, 4'hf, a, ptr[3:0] ^ 4'h9};
      @(negedge clk_i);
      chk({rrdo, busy, raddr}, {2'b11, ea});
      @(negedge clk_i);
      chk({busy, fwr, acc}, {1'b0, ea[3:0], ea[7:4] ^ {3'h0, ea[12]}});
    end
  endtask
  task automatic t_return();
    call(12'h5a3, 1'b0);
    call(12'h0c7, 1'b0);
    chk(pc, 12'h0c7);
    go(8'h2e);
    chk(pc, 12'h5a4);
    for (int c = 0; c < 2; c++) begin
      call(12'h31e, 1'b0);
      load({c[0], 3'h0});
      go(8'h01);
      call(12'hb40, 1'b1);
      load({!c[0], 3'h0});
      go(8'h01);
      go(8'h2f);
      chk({carry, pc}, {c[0], 12'h31f});
    end
  endtask
  task automatic t_refuse();
    call(12'h200, 1'b0);
    load(4'h6);
    pab3 = 1'b0;
    ptr = 8'h4b;
    op_i = 8'h4e;
    op_valid_i = 1'b1;
    @(negedge clk_i);
    op_i = 8'h01;
    tgt = 12'h777;
    call_i = 1'b1;
    repeat (2) @(negedge clk_i);
    op_valid_i = 1'b0;
    call_i = 1'b0;
    chk({pc, busy, fwr, acc}, {12'h201, 1'b0, 4'h2, 4'h6});
    @(negedge clk_i);
    vec = 12'h6d0;
    tgt = 12'h123;
    op_i = 8'h01;
    int_entry_i = 1'b1;
    call_i = 1'b1;
    op_valid_i = 1'b1;
    @(negedge clk_i);
    int_entry_i = 1'b0;
    chk({pc, acc}, {12'h6d0, 4'h6});
    @(negedge clk_i);
    call_i = 1'b0;
    chk(pc, 12'h123);
    @(negedge clk_i);
    op_i = 8'h2e;
    chk({carry, acc, pc}, {1'b0, 4'hc, 12'h124});
    @(negedge clk_i);
    op_valid_i = 1'b0;
    chk(pc, 12'h6d1);
  endtask
  task automatic t_reset();
    load(4'h9);
    op_i = 8'h4e;
    op_valid_i = 1'b1;
    @(negedge clk_i);
    op_valid_i = 1'b0;
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk({pc, acc, fwr, carry, busy, mrdo, rrdo}, 24'h000000);
    load(4'hc);
    go(8'h01);
    chk({carry, acc, busy}, {1'b1, 4'h9, 1'b0});
  endtask
  task automatic conclude();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk({pc, acc, fwr, carry, busy, mrdo, rrdo}, 24'h000000);
    t_rotate();
    t_table();
    t_return();
    t_refuse();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
